// File: dv/asbf_formatter_chk.sv
`default_nettype none
module asbf_formatter_chk (
  // Clock and request side
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic seq_start_i,
  input wire logic [3:0] seq_num_i,
  input wire logic system_50hz_i,
  input wire logic busy_o,
  input wire logic seq_refused_o,
  // Byte stream
  input wire logic [7:0] stream_block_byte_o,
  input wire logic stream_block_start_o,
  input wire logic stream_block_valid_o,
  input wire logic stream_block_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt;
  logic [2:0] sec;
  wire vb = stream_block_valid_o;
  wire tk = vb && stream_block_ready_i && ce_i;
  wire [7:0] by = stream_block_byte_o;
  wire req = ce_i && !busy_o && seq_start_i;
  wire ok = seq_num_i <= (system_50hz_i ? 4'hB : 4'h9);
  wire [6:0] q = cnt - 7'h03;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Position counted on consumed bytes, so stalls cannot skew it
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 7'h00;
      sec <= 3'h0;
    end else if (tk) begin
      cnt <= (cnt == 7'h4F) ? 7'h00 : cnt + 7'h01;
      if (cnt == 7'h00) sec <= by[7:5];
    end
  end
  a_start_taken: assert property (req && ok |=> busy_o && !seq_refused_o)
    else $error("accepted start gave no busy");
  a_start_refused: assert property (req && !ok |=> seq_refused_o && !busy_o)
    else $error("bad sequence number not refused");
  a_refuse_pulse: assert property (seq_refused_o |=> !seq_refused_o)
    else $error("refusal pulse too long");
  a_byte_hold: assert property (vb && !tk |=> vb && $stable(by)
    && $stable(stream_block_start_o)) else $error("byte changed unconsumed");
  a_first_byte: assert property ($rose(busy_o) |-> ##[0:3] vb)
    else $error("no byte after start");
  a_block_len: assert property (vb |-> stream_block_start_o == (cnt == 0))
    else $error("block start misplaced");
  a_id_section: assert property (vb && cnt == 7'h00
    |-> by[7:5] <= 3'h2 && by[4:0] == 5'h1F) else $error("bad id byte");
  a_dsf_bit: assert property (vb && sec == 3'h0 && cnt == 7'h03
    |-> by == {system_50hz_i, 1'b0, 6'h3F}) else $error("bad header byte 3");
  a_hdr_fill: assert property (vb && sec == 3'h0 && cnt > 7'h07
    |-> by == 8'hFF) else $error("header reserved not ones");
  a_sync_fill: assert property (vb && sec == 3'h1 && cnt > 7'h02
    && cnt < 7'h33 && q[2:0] == 3'h2 |-> by == 8'hFF) else $error("sync fill");
  a_sc_tail: assert property (vb && sec == 3'h1 && cnt > 7'h32
    |-> by == 8'hFF) else $error("subcode tail not ones");
  a_aux_tail: assert property (vb && sec == 3'h2 && cnt > 7'h4D
    |-> by == 8'hFF) else $error("aux tail not ones");
endmodule // asbf_formatter_chk
bind asbf_formatter asbf_formatter_chk u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .seq_start_i(seq_start_i), .seq_num_i(seq_num_i),
  .system_50hz_i(system_50hz_i), .busy_o(busy_o),
  .seq_refused_o(seq_refused_o), .stream_block_byte_o(stream_block_byte_o),
  .stream_block_start_o(stream_block_start_o),
  .stream_block_valid_o(stream_block_valid_o),
  .stream_block_ready_i(stream_block_ready_i));
`default_nettype wire

// File: dv/asbf_sink.sv
`default_nettype none
module asbf_sink (
  // Clock and control
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic [1:0] pace_i,
  // Byte stream
  input wire logic [7:0] byte_i,
  input wire logic start_i,
  input wire logic valid_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:479];
  logic [1:0] ph;
  int cnt;
  int bad;
  // Pace 0 prompt, 1 one edge in four, 2 stalled
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph <= 2'h0;
      ready_o <= 1'b0;
      cnt <= 0;
      bad <= 0;
    end else begin
      ph <= ph + 2'h1;
      ready_o <= pace_i == 2'h0 || (pace_i == 2'h1 && ph == 2'h3);
      if (clr_i) begin
        cnt <= 0;
      end else if (valid_i && ready_o && ce_i) begin
        if (cnt < 480) mem[cnt] <= byte_i;
        if (start_i !== (cnt % 80 == 0)) bad <= bad + 1;
        cnt <= cnt + 1;
      end
    end
  end
endmodule // asbf_sink
`default_nettype wire

// File: dv/tb_top.sv
`default_nettype none
`define CHK(a, b) begin \
  n_tests++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("Error at %0t: got %h want %h", $time, a, b); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1, st = 1'b0, s50 = 1'b0, kn = 1'b1, hk = 1'b1;
  logic ae = 1'b1, clr = 1'b0;
  logic [3:0] sq = 4'h0;
  logic [1:0] ch = 2'h1, pace = 2'h0, cc = 2'h0;
  logic [2:0] tf = 3'h5, dc = 3'h2;
  logic [4:0] sty = 5'h14;
  logic [66:0] fl = {3'h5, 64'h1234_5678_9ABC_DEF0};
  logic [66:0] cp = '1;
  wire busy, refd, bst, bvl, rdy;
  wire [7:0] byt;
  int n_tests = 0, miscompares = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  asbf_formatter DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce),
    .seq_start_i(st), .seq_num_i(sq), .channel_i(ch),
    .busy_o(busy), .seq_refused_o(refd),
    .system_50hz_i(s50), .source_known_i(kn), .half_known_i(hk),
    .audio_transmit_flag_i(tf[0]), .video_transmit_flag_i(tf[1]),
    .subcode_transmit_flag_i(tf[2]),
    .tc_frames_i(fl[66:61]), .tc_seconds_i(fl[60:54]),
    .tc_minutes_i(fl[53:47]), .tc_hours_i(fl[46:41]),
    .colour_frame_flag_i(fl[40]), .drop_frame_flag_i(fl[39]),
    .polarity_correction_bit_i(fl[38]), .group_flag_i(fl[37:35]),
    .binary_groups_i(fl[34:3]), .video_auxiliary_enable_i(ae),
    .signal_type_code_i(sty), .copy_code_i(cc), .display_code_i(dc),
    .frame_field_flag_i(fl[2]), .first_second_flag_i(fl[1]),
    .change_flag_i(fl[0]), .stream_block_byte_o(byt),
    .stream_block_start_o(bst), .stream_block_valid_o(bvl),
    .stream_block_ready_i(rdy));
  asbf_sink u_sink (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce),
    .clr_i(clr), .pace_i(pace), .byte_i(byt), .start_i(bst),
    .valid_i(bvl), .ready_o(rdy));
  // Expected byte p of block b; frame fields come from the latched copy
  function automatic logic [7:0] e(int b, int p);
    logic [7:0] t [5];
    logic [7:0] g [5];
    logic [7:0] vs [5];
    logic [7:0] vc [5];
    logic [2:0] ap;
    logic h;
    int k;
    int q;
    t = '{8'h13, {cp[40], s50 | cp[39], cp[66:61]},
      {s50 ? cp[35] : cp[38], cp[60:54]}, {s50 ? cp[37] : cp[35], cp[53:47]},
      {s50 ? cp[38] : cp[37], cp[36], cp[46:41]}};
    g = '{8'h14, cp[10:3], cp[18:11], cp[26:19], cp[34:27]};
    vs = '{8'h60, 8'hFF, 8'hFF, {2'h3, s50, sty}, 8'h7F};
    vc = '{8'h61, {cc, 6'h3F}, {4'hC, 1'b1, dc}, {cp[2:0], 5'h1C}, 8'hFF};
    ap = kn ? 3'h1 : 3'h7;
    h = !hk || sq < (s50 ? 6 : 5);
    if (p == 0) return {b == 0 ? 3'h0 : b < 3 ? 3'h1 : 3'h2, 5'h1F};
    if (p == 1) return {sq, ch[0], ~ch[1], 2'h3};
    if (p == 2) return b == 0 ? 8'h00 : b < 3 ? 8'(b - 1) : 8'(b - 3);
    if (b == 0) begin
      case (p)
        3: return {s50, 1'b0, 6'h3F};
        4: return {5'h1F, ap};
        5, 6, 7: return {tf[p - 5], 4'hF, ap};
        default: return 8'hFF;
      endcase
    end
    if (b < 3) begin
      k = (p - 3) / 8 + (b - 1) * 6;
      q = (p - 3) % 8;
      if (p > 50 || q == 2) return 8'hFF;
      if (q == 0) return {h, k % 6 == 0 || k == 11 ? ap : 3'h7, 4'hF};
      if (q == 1) return {4'hF, 4'(k)};
      if (k == 3 || k == 9 || h && (k == 5 || k == 11)) return t[q - 3];
      if (h && (k == 4 || k == 10)) return g[q - 3];
      return 8'hFF;
    end
    k = (b - 3) * 15 + (p - 3) / 5;
    q = (p - 3) % 5;
    if (p > 77 || !ae) return 8'hFF;
    if (k == (sq[0] ? 0 : 39)) return vs[q];
    if (k == (sq[0] ? 1 : 40)) return vc[q];
    return 8'hFF;
  endfunction
  // Pace 2 stalls past a full sequence; pace 3 freezes the clock enable
  task automatic run(input logic [3:0] s, input logic [1:0] pc);
    int i;
    @(posedge sys_clk_i);
    st <= 1'b1;
    sq <= s;
    clr <= 1'b1;
    pace <= (pc == 2'h3) ? 2'h0 : pc;
    if (s == 4'h0) cp <= fl;
    @(posedge sys_clk_i);
    clr <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    st <= 1'b0;
    if (pc == 2'h2) begin
      repeat (600) @(posedge sys_clk_i);
      #1;
      `CHK(busy, 1'b1)
      @(posedge sys_clk_i);
      pace <= 2'h0;
    end
    if (pc == 2'h3) begin
      repeat (50) @(posedge sys_clk_i);
      ce <= 1'b0;
      repeat (30) @(posedge sys_clk_i);
      ce <= 1'b1;
    end
    for (i = 0; i < 20000 && (u_sink.cnt != 480 || busy !== 1'b0); i++)
      @(posedge sys_clk_i);
    repeat (8) @(posedge sys_clk_i);
    #1;
    `CHK(u_sink.cnt, 480)
    `CHK(u_sink.bad, 0)
    for (i = 0; i < 480; i++)
      `CHK(u_sink.mem[i], e(i / 80, i % 80))
    @(posedge sys_clk_i);
  endtask
  task automatic refuse(input logic [3:0] s);
    @(posedge sys_clk_i);
    st <= 1'b1;
    sq <= s;
    @(posedge sys_clk_i);
    st <= 1'b0;
    #1;
    `CHK({refd, busy}, 2'h2)
    @(posedge sys_clk_i);
    #1;
    `CHK(refd, 1'b0)
    @(posedge sys_clk_i);
  endtask
  task automatic t_frame60;
    run(4'h0, 2'h0);
    fl <= ~fl;
    run(4'h1, 2'h1);
    kn <= 1'b0;
    tf <= 3'h2;
    run(4'h9, 2'h0);
    refuse(4'hA);
  endtask
  task automatic t_codes;
    logic [4:0] code [5] = '{5'h14, 5'h15, 5'h18, 5'h00, 5'h04};
    for (int j = 0; j < 5; j++) begin
      sty <= code[j];
      fl[2:0] <= 3'(j * 3);
      run(4'h0, 2'(j));
    end
  endtask
  task automatic t_frame50;
    s50 <= 1'b1;
    ch <= 2'h2;
    kn <= 1'b1;
    run(4'h0, 2'h0);
    run(4'h7, 2'h0);
    hk <= 1'b0;
    run(4'hB, 2'h1);
    ae <= 1'b0;
    run(4'h2, 2'h0);
    refuse(4'hC);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    `CHK({busy, refd, bvl, bst, byt}, 12'h000)
    t_frame60();
    t_codes();
    t_frame50();
    end_sim();
  end
  // Runs take about 11000 cycles; allow well over three times that
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire

// File: hdl/asbf_defines.vh
`ifndef ASBF_DEFINES_VH
`define ASBF_DEFINES_VH

// Block geometry
`define ASBF_BLOCK_LAST 7'h4F
`define ASBF_ID_LAST 7'h02
`define ASBF_HDR_LAST 7'h07
`define ASBF_SC_LAST 7'h32
`define ASBF_VA_LAST 7'h4D
`define ASBF_BLOCKS_LAST 3'h5

// Position of each block in a sequence
`define ASBF_BLK_HEADER 3'h0
`define ASBF_BLK_SC0 3'h1
`define ASBF_BLK_SC1 3'h2
`define ASBF_BLK_VA0 3'h3
`define ASBF_BLK_VA1 3'h4

// Section type codes
`define ASBF_SCT_HEADER 3'h0
`define ASBF_SCT_SUBCODE 3'h1
`define ASBF_SCT_VIDEO_AUXILIARY 3'h2

// Unit sizes inside payloads
`define ASBF_SUBCODE_SYNC_BLOCK_POS_LAST 3'h7
`define ASBF_PACK_POS_LAST 3'h4
`define ASBF_SUBCODE_SYNC_BLOCK_PER_BLK 4'h6
`define ASBF_PACKS_PER_BLK 6'h0F

// Sequence counts
`define ASBF_SEQ_LAST_60 4'h9
`define ASBF_SEQ_LAST_50 4'hB
`define ASBF_HALF_60 4'h5
`define ASBF_HALF_50 4'h6

// Fixed byte values
`define ASBF_FILL 8'hFF
`define ASBF_APP_ID_KNOWN 3'h1
`define ASBF_APP_ID_UNKNOWN 3'h7
`define ASBF_PC0_TIME_CODE 8'h13
`define ASBF_PC0_BINARY_GROUP 8'h14
`define ASBF_PC0_VSRC 8'h60
`define ASBF_PC0_VSRC_CTRL 8'h61

// Pack numbers of the video source packs
`define ASBF_VS_EVEN 6'h27
`define ASBF_VSC_EVEN 6'h28
`define ASBF_VS_ODD 6'h00
`define ASBF_VSC_ODD 6'h01

// Output buffer
`define ASBF_FIFO_DEPTH 16
`define ASBF_FIFO_AW 4
`define ASBF_FIFO_W 9

`endif

// File: hdl/asbf_fifo.v
`default_nettype none

module asbf_fifo #(
  parameter W = 9,
  parameter D = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // Fill side
  input wire wr_valid_i,
  output wire wr_ready_o,
  input wire [W-1:0] wr_data_i,
  // Drain side
  output wire rd_valid_o,
  input wire rd_ready_i,
  output wire [W-1:0] rd_data_o
);

  reg [W-1:0] mem [0:D-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign wr_ready_o = ~full;
  assign rd_valid_o = ~empty;
  assign rd_data_o = mem[rd_ptr[AW-1:0]];
  assign do_wr = ce_i & wr_valid_i & ~full;
  assign do_rd = ce_i & rd_ready_i & ~empty;

  always @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_i;
    end
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // asbf_fifo

`default_nettype wire

// File: hdl/asbf_formatter.v
// Function
// R1: Each block is 80 bytes: 3 identifier bytes then 77 payload bytes.
// R2: Header payload bytes 3 to 7 defined; bytes 8 to 79 all ones.
// R3: Identifier byte 0 top three bits hold the section type code.
// R4: Sequence count flag 0 for ten sequences, 1 for twelve.
// R5: Application IDs are 001 for compatible source, all ones if unknown.
// R6: Audio, video and subcode transmit flags: 0 valid, 1 invalid.
// R7: Reserved bits in header, subcode and aux structures default to 1.
// R8: Subcode blocks use section type code 001.
// R9: Subcode payload: six 8-byte sync blocks then 29 reserved bytes.
// R10: Sync block: 2 identifier bytes, one FFh byte, 5-byte pack.
// R11: Sync id carries half flag, app ID per number, and sync number.
// R12: Half flag 1 first half, 0 second half, 1 when unknown.
// R13: Time code and binary group packs sit at fixed sync numbers.
// R14: Time code and binary group contents constant through a frame.
// R15: Time code pack header 13h, then BCD frames, seconds, minutes, hours.
// R16: Time code flag bit positions differ between 60 Hz and 50 Hz.
// R17: Binary group pack header 14h, odd group in low nibble.
// R18: Video auxiliary blocks use section type code 010.
// R19: Aux payload: fifteen 5-byte packs plus two FFh bytes.
// R20: Source packs at 39/40 in even sequences, 0/1 in odd; rest FFh.
// R21: With no aux data sent, packs are no-information, all FFh.
// R22: Source pack header 60h, system bit, signal type, byte 4 bit 7 zero.
// R23: Signal type codes select 1080, 1035 or 720 line formats.
// R24: Source control header 61h with copy, display and field flags.
// R25: Frame/field and first/second flags choose the output order.
// R26: Change flag 1 when the picture differs, 0 when it repeats.
// R27: Bytes leave one per clock with block start and valid qualifier.
`include "asbf_defines.vh"
`default_nettype none

module asbf_formatter (
  // Clock, reset, enable
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // Sequence request
  input wire seq_start_i,
  input wire [3:0] seq_num_i,
  input wire [1:0] channel_i,
  output reg busy_o,
  output reg seq_refused_o,
  // Stream configuration
  input wire system_50hz_i,
  input wire source_known_i,
  input wire half_known_i,
  input wire audio_transmit_flag_i,
  input wire video_transmit_flag_i,
  input wire subcode_transmit_flag_i,
  // Time code and binary groups
  input wire [5:0] tc_frames_i,
  input wire [6:0] tc_seconds_i,
  input wire [6:0] tc_minutes_i,
  input wire [5:0] tc_hours_i,
  input wire colour_frame_flag_i,
  input wire drop_frame_flag_i,
  input wire polarity_correction_bit_i,
  input wire [2:0] group_flag_i,
  input wire [31:0] binary_groups_i,
  // Video auxiliary content
  input wire video_auxiliary_enable_i,
  input wire [4:0] signal_type_code_i,
  input wire [1:0] copy_code_i,
  input wire [2:0] display_code_i,
  input wire frame_field_flag_i,
  input wire first_second_flag_i,
  input wire change_flag_i,
  // Byte stream out
  output reg [7:0] stream_block_byte_o,
  output reg stream_block_start_o,
  output reg stream_block_valid_o,
  input wire stream_block_ready_i
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state;
  reg [2:0] blk;
  reg [6:0] byte_cnt;
  reg [2:0] unit_pos;
  reg [3:0] unit_idx;
  reg [3:0] seq;
  reg [1:0] chan;

  // Per-frame copies so every time code, binary group and control flag byte of one frame matches
  reg [5:0] tc_frames;
  reg [6:0] tc_seconds;
  reg [6:0] tc_minutes;
  reg [5:0] tc_hours;
  reg tc_cf;
  reg tc_df;
  reg tc_pc;
  reg [2:0] tc_bgf;
  reg [31:0] bg_data;
  reg vsc_ff;
  reg vsc_fs;
  reg vsc_fc;

  reg [7:0] next_byte;
  wire gen_valid;
  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire fifo_rd_ready;
  wire [8:0] fifo_rd_data;
  wire take;
  wire seq_ok;
  wire is_subcode;
  wire is_video_auxiliary;
  wire first_half;
  wire [3:0] syb_num;
  wire [5:0] pack_num;
  wire [2:0] app_id;
  wire unit_last;

  function [2:0] sct_of;
    input [2:0] b;
    begin
      if (b == `ASBF_BLK_HEADER) begin
        sct_of = `ASBF_SCT_HEADER;
      end else if (b <= `ASBF_BLK_SC1) begin
        sct_of = `ASBF_SCT_SUBCODE;
      end else begin
        sct_of = `ASBF_SCT_VIDEO_AUXILIARY;
      end
    end
  endfunction

  // Block number inside its own section
  function [7:0] dbn_of;
    input [2:0] b;
    begin
      case (b)
        `ASBF_BLK_SC1: dbn_of = 8'h01;
        `ASBF_BLK_VA0: dbn_of = 8'h00;
        `ASBF_BLK_VA1: dbn_of = 8'h01;
        `ASBF_BLOCKS_LAST: dbn_of = 8'h02;
        default: dbn_of = 8'h00;
      endcase
    end
  endfunction

  // Time code pack byte; flag placement follows the system
  function [7:0] tc_byte;
    input [2:0] p;
    input sys50;
    begin
      case (p)
        3'h0: tc_byte = `ASBF_PC0_TIME_CODE; // R15
        3'h1: tc_byte = {tc_cf, sys50 | tc_df, tc_frames}; // R16
        3'h2: tc_byte = {sys50 ? tc_bgf[0] : tc_pc, tc_seconds}; // R16
        3'h3: tc_byte = {sys50 ? tc_bgf[2] : tc_bgf[0], tc_minutes}; // R16
        3'h4: tc_byte = sys50 ? {tc_pc, tc_bgf[1], tc_hours} :
                                {tc_bgf[2], tc_bgf[1], tc_hours}; // R16
        default: tc_byte = `ASBF_FILL;
      endcase
    end
  endfunction

  function [7:0] bg_byte;
    input [2:0] p;
    begin
      case (p)
        3'h0: bg_byte = `ASBF_PC0_BINARY_GROUP; // R17
        3'h1: bg_byte = bg_data[7:0]; // R17
        3'h2: bg_byte = bg_data[15:8];
        3'h3: bg_byte = bg_data[23:16];
        3'h4: bg_byte = bg_data[31:24];
        default: bg_byte = `ASBF_FILL;
      endcase
    end
  endfunction

  function [7:0] vs_byte;
    input [2:0] p;
    begin
      case (p)
        3'h0: vs_byte = `ASBF_PC0_VSRC; // R22
        3'h3: vs_byte = {2'h3, system_50hz_i, signal_type_code_i}; // R23
        3'h4: vs_byte = 8'h7F; // R22
        default: vs_byte = `ASBF_FILL; // R7
      endcase
    end
  endfunction

  function [7:0] vsc_byte;
    input [2:0] p;
    begin
      case (p)
        3'h0: vsc_byte = `ASBF_PC0_VSRC_CTRL; // R24
        3'h1: vsc_byte = {copy_code_i, 6'h3F}; // R24
        3'h2: vsc_byte = {4'hC, 1'b1, display_code_i}; // R24
        3'h3: vsc_byte = {vsc_ff, vsc_fs, vsc_fc, 3'h7, 2'h0}; // R25 R26
        default: vsc_byte = `ASBF_FILL; // R7
      endcase
    end
  endfunction

  assign seq_ok = (seq_num_i <= (system_50hz_i ? `ASBF_SEQ_LAST_50 :
                                                 `ASBF_SEQ_LAST_60));
  assign is_subcode = (sct_of(blk) == `ASBF_SCT_SUBCODE);
  assign is_video_auxiliary = (sct_of(blk) == `ASBF_SCT_VIDEO_AUXILIARY);
  // Unknown half is sent as all ones, so it is laid out as first half
  assign first_half = ~half_known_i |
    (seq < (system_50hz_i ? `ASBF_HALF_50 : `ASBF_HALF_60)); // R12
  assign syb_num = (blk == `ASBF_BLK_SC1) ?
    unit_idx + `ASBF_SUBCODE_SYNC_BLOCK_PER_BLK : unit_idx; // R9
  assign pack_num = (blk == `ASBF_BLK_VA0) ? {2'h0, unit_idx} :
                    (blk == `ASBF_BLK_VA1) ?
                    `ASBF_PACKS_PER_BLK + {2'h0, unit_idx} :
                    `ASBF_PACKS_PER_BLK + `ASBF_PACKS_PER_BLK +
                    {2'h0, unit_idx}; // R19
  assign app_id = source_known_i ? `ASBF_APP_ID_KNOWN :
                                   `ASBF_APP_ID_UNKNOWN; // R5
  assign unit_last = is_subcode ? (unit_pos == `ASBF_SUBCODE_SYNC_BLOCK_POS_LAST) :
                                  (unit_pos == `ASBF_PACK_POS_LAST);
  assign gen_valid = (state == ST_RUN);
  assign take = ce_i & gen_valid & fifo_wr_ready;

  always @* begin
    next_byte = `ASBF_FILL; // R2 R7
    if (byte_cnt == 7'h00) begin
      next_byte = {sct_of(blk), 1'b1, 4'hF}; // R3 R8 R18
    end else if (byte_cnt == 7'h01) begin
      next_byte = {seq, chan[0], ~chan[1], 2'h3};
    end else if (byte_cnt == `ASBF_ID_LAST) begin
      next_byte = dbn_of(blk);
    end else if (blk == `ASBF_BLK_HEADER) begin
      case (byte_cnt)
        7'h03: next_byte = {system_50hz_i, 1'b0, 6'h3F}; // R4
        7'h04: next_byte = {5'h1F, app_id}; // R5
        7'h05: next_byte = {audio_transmit_flag_i, 4'hF, app_id}; // R6
        7'h06: next_byte = {video_transmit_flag_i, 4'hF, app_id}; // R6
        7'h07: next_byte = {subcode_transmit_flag_i, 4'hF, app_id}; // R6
        default: next_byte = `ASBF_FILL; // R2
      endcase
    end else if (is_subcode && byte_cnt <= `ASBF_SC_LAST) begin
      case (unit_pos)
        3'h0: begin
          if (syb_num == 4'h0 || syb_num == 4'h6) begin
            next_byte = {first_half, app_id, 4'hF}; // R11
          end else if (syb_num == 4'hB) begin
            next_byte = {first_half, app_id, 4'hF}; // R11
          end else begin
            next_byte = {first_half, 7'h7F}; // R11
          end
        end
        3'h1: next_byte = {4'hF, syb_num}; // R11
        3'h2: next_byte = `ASBF_FILL; // R10
        default: begin
          if (syb_num == 4'h3 || syb_num == 4'h9 ||
              (first_half && (syb_num == 4'h5 || syb_num == 4'hB))) begin
            next_byte = tc_byte(unit_pos - 3'h3, system_50hz_i); // R13
          end else if (first_half &&
                       (syb_num == 4'h4 || syb_num == 4'hA)) begin
            next_byte = bg_byte(unit_pos - 3'h3); // R13
          end else begin
            next_byte = `ASBF_FILL; // R13
          end
        end
      endcase
    end else if (is_video_auxiliary && byte_cnt <= `ASBF_VA_LAST &&
                 video_auxiliary_enable_i) begin // R21
      if (pack_num == (seq[0] ? `ASBF_VS_ODD : `ASBF_VS_EVEN)) begin
        next_byte = vs_byte(unit_pos); // R20
      end else if (pack_num == (seq[0] ? `ASBF_VSC_ODD :
                                         `ASBF_VSC_EVEN)) begin
        next_byte = vsc_byte(unit_pos); // R20
      end else begin
        next_byte = `ASBF_FILL; // R20
      end
    end
  end

  // Sequence walker
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      blk <= 3'h0;
      byte_cnt <= 7'h00;
      unit_pos <= 3'h0;
      unit_idx <= 4'h0;
      seq <= 4'h0;
      chan <= 2'h0;
      busy_o <= 1'b0;
      seq_refused_o <= 1'b0;
    end else if (ce_i) begin
      seq_refused_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (seq_start_i && seq_ok) begin
            state <= ST_RUN;
            busy_o <= 1'b1;
            seq <= seq_num_i;
            chan <= channel_i;
            blk <= 3'h0;
            byte_cnt <= 7'h00;
          end else if (seq_start_i) begin
            seq_refused_o <= 1'b1;
          end
        end
        ST_RUN: begin
          if (take) begin
            if (byte_cnt == `ASBF_BLOCK_LAST) begin // R1
              byte_cnt <= 7'h00;
              if (blk == `ASBF_BLOCKS_LAST) begin
                state <= ST_IDLE;
                busy_o <= 1'b0;
              end else begin
                blk <= blk + 3'h1;
              end
            end else begin
              byte_cnt <= byte_cnt + 7'h01;
            end
            if (byte_cnt == `ASBF_ID_LAST) begin
              unit_pos <= 3'h0;
              unit_idx <= 4'h0;
            end else if (unit_last) begin
              unit_pos <= 3'h0;
              unit_idx <= unit_idx + 4'h1;
            end else begin
              unit_pos <= unit_pos + 3'h1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Frame content captured at sequence 0 only
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tc_frames <= 6'h3F;
      tc_seconds <= 7'h7F;
      tc_minutes <= 7'h7F;
      tc_hours <= 6'h3F;
      tc_cf <= 1'b1;
      tc_df <= 1'b1;
      tc_pc <= 1'b1;
      tc_bgf <= 3'h7;
      bg_data <= 32'hFFFFFFFF;
      vsc_ff <= 1'b1;
      vsc_fs <= 1'b1;
      vsc_fc <= 1'b1;
    end else if (ce_i && state == ST_IDLE && seq_start_i && seq_ok &&
                 seq_num_i == 4'h0) begin // R14
      tc_frames <= tc_frames_i;
      tc_seconds <= tc_seconds_i;
      tc_minutes <= tc_minutes_i;
      tc_hours <= tc_hours_i;
      tc_cf <= colour_frame_flag_i;
      tc_df <= drop_frame_flag_i;
      tc_pc <= polarity_correction_bit_i;
      tc_bgf <= group_flag_i;
      bg_data <= binary_groups_i;
      vsc_ff <= frame_field_flag_i; // R25
      vsc_fs <= first_second_flag_i; // R25
      vsc_fc <= change_flag_i; // R26
    end
  end

  // Buffer lets the walker run ahead while the consumer stalls
  asbf_fifo #(
    .W(`ASBF_FIFO_W),
    .D(`ASBF_FIFO_DEPTH),
    .AW(`ASBF_FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_valid_i(gen_valid),
    .wr_ready_o(fifo_wr_ready),
    .wr_data_i({byte_cnt == 7'h00, next_byte}),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(fifo_rd_ready),
    .rd_data_o(fifo_rd_data)
  );

  assign fifo_rd_ready = ~stream_block_valid_o | stream_block_ready_i;

  // Registered output stage
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stream_block_byte_o <= 8'h00;
      stream_block_start_o <= 1'b0;
      stream_block_valid_o <= 1'b0;
    end else if (ce_i && fifo_rd_ready) begin // R27
      stream_block_valid_o <= fifo_rd_valid;
      stream_block_byte_o <= fifo_rd_valid ? fifo_rd_data[7:0] : 8'h00;
      stream_block_start_o <= fifo_rd_valid & fifo_rd_data[8];
    end
  end

endmodule // asbf_formatter

`default_nettype wire
